// File: rtl/lupc_ctrl.v
// slave side controller for half-duplex uart passthrough on the line
// assumes all inputs synchronous to I_CLK_SYS; pulses last one cycle
//
// Overview of operation
// - master mode request enters passthrough mode
// - two-bit select maps to switch pairs
// - successful master request closes selected switches when auto direction is off
// - host writes override switches during passthrough
// - own request enters mode, no switches closed
// - four-bit master select forwarded in command
// - host disable write exits mode at once
// - idle timeout runs only when enabled
// - half second idle opens switches, starts delay
// - delay expiry reconnects engine, resumes detection
// - exit sequence cannot be cancelled by activity
// - detection pulses start right after exit
// - timeout exit raises an event
// - auto direction starts on transmit path
// - return to transmit after blanking interval
`timescale 1ns/1ns
`include "lupc_defs.vh"

module lupc_ctrl #(
  parameter [31:0] IDLE_CYCLES = `LUPC_IDLE_TIME_MS * `LUPC_CLK_KHZ,
  parameter [31:0] EXIT_CYCLES = `LUPC_EXIT_TIME_MS * `LUPC_CLK_KHZ
) (
  input  wire                     I_CLK_SYS,
  input  wire                     I_RST,
  input  wire                     I_MODE_REQ_DONE,
  input  wire [1:0]               I_SLAVE_SWITCH_SELECT,
  input  wire                     I_OWN_REQ_DONE,
  input  wire [3:0]               I_MASTER_SWITCH_SELECT,
  input  wire                     I_HOST_WR,
  input  wire                     I_HOST_MODE_EN,
  input  wire                     I_HOST_TX_SW,
  input  wire                     I_HOST_RX_SW,
  input  wire                     I_TMO_EN,
  input  wire                     I_AUTO_DIR_EN,
  input  wire [`LUPC_BLANK_W-1:0] I_BLANK_CYCLES,
  input  wire                     I_LINE_DATA,
  input  wire                     I_UART_RX_PIN,
  output wire                     O_SW_TX,
  output wire                     O_SW_RX,
  output wire                     O_PASS_ACTIVE,
  output wire                     O_ENGINE_CONNECT,
  output wire                     O_EXITING,
  output wire [3:0]               O_MASTER_SWITCH_SELECT,
  output wire                     O_DETECT_START,
  output wire                     O_TIMEOUT_EVENT
);

  reg  [1:0]               state_reg;
  reg  [1:0]               state_next;
  reg                      sw_tx_reg;
  reg                      sw_tx_next;
  reg                      sw_rx_reg;
  reg                      sw_rx_next;
  reg  [`LUPC_CNT_W-1:0]   cnt_reg;
  reg  [`LUPC_CNT_W-1:0]   cnt_next;
  reg  [`LUPC_BLANK_W-1:0] blank_reg;
  reg  [`LUPC_BLANK_W-1:0] blank_next;
  reg  [3:0]               msel_reg;
  reg  [3:0]               msel_next;
  reg                      det_reg;
  reg                      det_next;
  reg                      tmo_reg;
  reg                      tmo_next;
  reg                      line_prev_reg;
  reg                      rxpin_prev_reg;
  wire                     line_edge;
  wire                     rxpin_edge;
  wire                     path_edge;
  wire [`LUPC_CNT_W-1:0]   idle_last;
  wire [`LUPC_CNT_W-1:0]   exit_last;

  // switch pair for a two-bit select: {tx, rx}
  function [1:0] sel_switches;
    input [1:0] sel;
    begin
      case (sel)
        `LUPC_SEL_RX:  sel_switches = 2'b01;
        `LUPC_SEL_TX:  sel_switches = 2'b10;
        `LUPC_SEL_ALL: sel_switches = 2'b11;
        default:       sel_switches = 2'b00;
      endcase
    end
  endfunction

  // terminal count of a cycle figure
  function [`LUPC_CNT_W-1:0] last_count;
    input [31:0] cycles;
    reg   [31:0] tmp;
    begin
      tmp = (cycles > 32'h0000_0001) ? cycles - 32'h0000_0001 : 32'h0000_0000;
      last_count = tmp[`LUPC_CNT_W-1:0];
    end
  endfunction

  assign idle_last  = last_count(IDLE_CYCLES);
  assign exit_last  = last_count(EXIT_CYCLES);
  assign line_edge  = I_LINE_DATA ^ line_prev_reg;
  assign rxpin_edge = I_UART_RX_PIN ^ rxpin_prev_reg;
  // activity on either pin counts while either switch is closed
  assign path_edge  = (sw_tx_reg & line_edge) | (sw_rx_reg & rxpin_edge) |
                      (sw_rx_reg & line_edge) | (sw_tx_reg & rxpin_edge);

  always @* begin
    state_next = state_reg;
    sw_tx_next = sw_tx_reg;
    sw_rx_next = sw_rx_reg;
    cnt_next   = cnt_reg;
    blank_next = blank_reg;
    msel_next  = msel_reg;
    det_next   = 1'b0;
    tmo_next   = 1'b0;
    case (state_reg)
      `LUPC_ST_ENGINE: begin
        cnt_next   = `LUPC_CNT_ZERO;
        blank_next = `LUPC_BLANK_ZERO;
        if (I_MODE_REQ_DONE) begin
          state_next = `LUPC_ST_PASS;
          if (I_AUTO_DIR_EN) begin
            sw_tx_next = 1'b1;
            sw_rx_next = 1'b0;
          end else begin
            {sw_tx_next, sw_rx_next} =
              sel_switches(I_SLAVE_SWITCH_SELECT);
          end
        end else if (I_OWN_REQ_DONE) begin
          state_next = `LUPC_ST_PASS;
          sw_tx_next = 1'b0;
          sw_rx_next = 1'b0;
        end else if (I_HOST_WR && I_HOST_MODE_EN) begin
          state_next = `LUPC_ST_PASS;
          sw_tx_next = I_HOST_TX_SW;
          sw_rx_next = I_HOST_RX_SW;
        end
        if (I_OWN_REQ_DONE) begin
          msel_next = I_MASTER_SWITCH_SELECT;
        end
      end
      `LUPC_ST_PASS: begin
        if (I_HOST_WR && !I_HOST_MODE_EN) begin
          state_next = `LUPC_ST_ENGINE;
          sw_tx_next = 1'b0;
          sw_rx_next = 1'b0;
          det_next   = 1'b1;
        end else begin
          if (I_HOST_WR) begin
            sw_tx_next = I_HOST_TX_SW;
            sw_rx_next = I_HOST_RX_SW;
          end else if (I_AUTO_DIR_EN && (sw_tx_reg || sw_rx_reg)) begin
            if (rxpin_edge) begin
              sw_tx_next = 1'b0;
              sw_rx_next = 1'b1;
              blank_next = `LUPC_BLANK_ZERO;
            end else if (sw_rx_reg && !sw_tx_reg) begin
              if (blank_reg >= I_BLANK_CYCLES) begin
                sw_tx_next = 1'b1;
                sw_rx_next = 1'b0;
                blank_next = `LUPC_BLANK_ZERO;
              end else begin
                blank_next = blank_reg + `LUPC_BLANK_ONE;
              end
            end
          end
          if (path_edge || !I_TMO_EN || I_HOST_WR) begin
            cnt_next = `LUPC_CNT_ZERO;
          end else if (cnt_reg >= idle_last) begin
            state_next = `LUPC_ST_EXIT;
            sw_tx_next = 1'b0;
            sw_rx_next = 1'b0;
            cnt_next   = `LUPC_CNT_ZERO;
          end else begin
            cnt_next = cnt_reg + `LUPC_CNT_ONE;
          end
        end
      end
      `LUPC_ST_EXIT: begin
        // activity and host writes are ignored here
        sw_tx_next = 1'b0;
        sw_rx_next = 1'b0;
        if (cnt_reg >= exit_last) begin
          state_next = `LUPC_ST_ENGINE;
          cnt_next   = `LUPC_CNT_ZERO;
          det_next   = 1'b1;
          tmo_next   = 1'b1;
        end else begin
          cnt_next = cnt_reg + `LUPC_CNT_ONE;
        end
      end
      default: begin
        state_next = `LUPC_ST_ENGINE;
        sw_tx_next = 1'b0;
        sw_rx_next = 1'b0;
        cnt_next   = `LUPC_CNT_ZERO;
      end
    endcase
  end

  always @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      state_reg      <= `LUPC_ST_ENGINE;
      sw_tx_reg      <= 1'b0;
      sw_rx_reg      <= 1'b0;
      cnt_reg        <= `LUPC_CNT_ZERO;
      blank_reg      <= `LUPC_BLANK_ZERO;
      msel_reg       <= `LUPC_MSEL_ZERO;
      det_reg        <= 1'b0;
      tmo_reg        <= 1'b0;
      line_prev_reg  <= I_LINE_DATA;
      rxpin_prev_reg <= I_UART_RX_PIN;
    end else begin
      state_reg      <= state_next;
      sw_tx_reg      <= sw_tx_next;
      sw_rx_reg      <= sw_rx_next;
      cnt_reg        <= cnt_next;
      blank_reg      <= blank_next;
      msel_reg       <= msel_next;
      det_reg        <= det_next;
      tmo_reg        <= tmo_next;
      line_prev_reg  <= I_LINE_DATA;
      rxpin_prev_reg <= I_UART_RX_PIN;
    end
  end

  assign O_SW_TX                = sw_tx_reg;
  assign O_SW_RX                = sw_rx_reg;
  assign O_PASS_ACTIVE          = (state_reg == `LUPC_ST_PASS);
  assign O_EXITING              = (state_reg == `LUPC_ST_EXIT);
  assign O_ENGINE_CONNECT       = (state_reg == `LUPC_ST_ENGINE);
  assign O_MASTER_SWITCH_SELECT = msel_reg;
  assign O_DETECT_START         = det_reg;
  assign O_TIMEOUT_EVENT        = tmo_reg;

endmodule

// File: shared/lupc_defs.vh
// constants for the line passthrough controller
// assumes a 100 MHz system clock
`ifndef LUPC_DEFS_VH
`define LUPC_DEFS_VH
`define LUPC_CLK_KHZ        100000
`define LUPC_IDLE_TIME_MS   500
`define LUPC_EXIT_TIME_MS   600
`define LUPC_CNT_W          26
`define LUPC_BLANK_W        16
`define LUPC_SEL_OFF        2'b00
`define LUPC_SEL_RX         2'b01
`define LUPC_SEL_TX         2'b10
`define LUPC_SEL_ALL        2'b11
`define LUPC_ST_ENGINE      2'b00
`define LUPC_ST_PASS        2'b01
`define LUPC_ST_EXIT        2'b10
`define LUPC_CNT_ZERO       26'h000_0000
`define LUPC_CNT_ONE        26'h000_0001
`define LUPC_BLANK_ZERO     16'h0000
`define LUPC_BLANK_ONE      16'h0001
`define LUPC_MSEL_ZERO      4'h0
`endif

// File: bench/lupc_ctrl_asserts.sv
// assertions on the lupc_ctrl ports
// assumes a bind from the bench top file
`timescale 1ns/1ns
module lupc_chk (
  input wire       I_CLK_SYS,
  input wire       I_RST,
  input wire       I_MODE_REQ_DONE,
  input wire       I_HOST_WR,
  input wire       I_HOST_MODE_EN,
  input wire       I_HOST_TX_SW,
  input wire       I_HOST_RX_SW,
  input wire       I_TMO_EN,
  input wire       I_AUTO_DIR_EN,
  input wire       I_UART_RX_PIN,
  input wire       O_SW_TX,
  input wire       O_SW_RX,
  input wire       O_PASS_ACTIVE,
  input wire       O_ENGINE_CONNECT,
  input wire       O_EXITING,
  input wire       O_DETECT_START,
  input wire       O_TIMEOUT_EVENT,
  input wire [1:0] I_SLAVE_SWITCH_SELECT
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  wire host_on  = I_HOST_WR && I_HOST_MODE_EN && O_PASS_ACTIVE;
  wire host_off = I_HOST_WR && !I_HOST_MODE_EN && O_PASS_ACTIVE;
  chk_req_switch_set:
    assert property (I_MODE_REQ_DONE && O_ENGINE_CONNECT && !I_AUTO_DIR_EN
      |=> {O_SW_TX, O_SW_RX} == $past(I_SLAVE_SWITCH_SELECT) && O_PASS_ACTIVE)
      else $error("mode request switches wrong");
  chk_host_override:
    assert property (host_on |=> O_SW_TX == $past(I_HOST_TX_SW)
      && O_SW_RX == $past(I_HOST_RX_SW)) else $error("host write lost");
  chk_host_exit:
    assert property (host_off |=> O_ENGINE_CONNECT && O_DETECT_START
      && !O_TIMEOUT_EVENT && !O_SW_TX && !O_SW_RX)
      else $error("host disable not immediate");
  chk_exit_open:
    assert property (O_EXITING |-> !O_SW_TX && !O_SW_RX && !O_PASS_ACTIVE)
      else $error("switch closed during exit");
  chk_exit_hold:
    assert property ($rose(O_EXITING) |-> O_EXITING [*8])
      else $error("exit sequence cut short");
  chk_exit_done:
    assert property ($fell(O_EXITING) |-> O_ENGINE_CONNECT && O_DETECT_START
      && O_TIMEOUT_EVENT) else $error("exit end pulses missing");
  chk_tmo_gate:
    assert property (!I_TMO_EN && !O_EXITING |=> !O_EXITING)
      else $error("exit without timeout enable");
  chk_auto_rx:
    assert property (I_AUTO_DIR_EN && O_PASS_ACTIVE && !I_HOST_WR
      && (O_SW_TX || O_SW_RX) && $changed(I_UART_RX_PIN)
      |=> O_SW_RX && !O_SW_TX) else $error("auto direction missed edge");
  cover property ($fell(O_EXITING));
  cover property (host_off);
  cover property (I_AUTO_DIR_EN && O_SW_RX && !O_SW_TX);
endmodule

// File: bench/lupc_master_model.sv
// charging case master device model
// assumes tasks are called by the bench top
`timescale 1ns/1ns
module lupc_master_model #(
  parameter int MIDLE = 30
) (
  input  wire       clk,
  input  wire       exiting,
  output reg        req_done = 1'b0,
  output reg  [1:0] sel = 2'b00,
  output reg        own_ack = 1'b0,
  output reg  [3:0] msel = 4'h0,
  output reg        line = 1'b1,
  output reg        pass_on = 1'b0
);
  int idle_cnt = 0;
  reg line_q   = 1'b1;
  // master idle timer, restarted by any line change
  always @(posedge clk) begin
    line_q <= line;
    if (req_done || own_ack) begin
      pass_on  <= 1'b1;
      idle_cnt <= 0;
    end else if (line !== line_q) begin
      idle_cnt <= 0;
    end else if (pass_on && idle_cnt >= MIDLE - 1) begin
      pass_on <= 1'b0;
    end else if (pass_on) begin
      idle_cnt <= idle_cnt + 1;
    end
  end
  task req(input [1:0] s);
    begin
      @(posedge clk) req_done <= 1'b1;
      sel <= s;
      @(posedge clk) req_done <= 1'b0;
    end
  endtask
  task own(input [3:0] s);
    begin
      @(posedge clk) own_ack <= 1'b1;
      msel <= s;
      @(posedge clk) own_ack <= 1'b0;
    end
  endtask
  task burst(input int k);
    repeat (k) @(posedge clk) if (!exiting) line <= ~line;
  endtask
endmodule

// File: bench/lupc_ctrl_tb_top.sv
// self-checking bench for lupc_ctrl
// assumes the master model on the line side
`timescale 1ns/1ns
module lupc_ctrl_tb_top;
  localparam int IDLE = 20;
  localparam int EXIT = 30;
  localparam int MIDLE = 30;
  reg clk = 1'b0, rst = 1'b1, wr = 1'b0, men = 1'b0, tx = 1'b0, rx = 1'b0;
  reg tmo = 1'b0, auto = 1'b0, rxp = 1'b0;
  reg [15:0] blank = 16'h0005;
  wire rq, oa, line, stx, srx, pass, eng, exg, det, tev, mpass;
  wire [1:0] sel;
  wire [3:0] msel, mq;
  int err_total = 0, samples_checked = 0, n, i;
  always #5 clk = ~clk;
  lupc_master_model #(.MIDLE(MIDLE)) m (.clk(clk), .exiting(exg),
    .req_done(rq), .sel(sel), .own_ack(oa), .msel(msel), .line(line),
    .pass_on(mpass));
  lupc_ctrl #(.IDLE_CYCLES(IDLE), .EXIT_CYCLES(EXIT)) DUT (.I_CLK_SYS(clk),
    .I_RST(rst), .I_MODE_REQ_DONE(rq), .I_SLAVE_SWITCH_SELECT(sel),
    .I_OWN_REQ_DONE(oa), .I_MASTER_SWITCH_SELECT(msel), .I_HOST_WR(wr),
    .I_HOST_MODE_EN(men), .I_HOST_TX_SW(tx), .I_HOST_RX_SW(rx),
    .I_TMO_EN(tmo), .I_AUTO_DIR_EN(auto), .I_BLANK_CYCLES(blank),
    .I_LINE_DATA(line), .I_UART_RX_PIN(rxp), .O_SW_TX(stx), .O_SW_RX(srx),
    .O_PASS_ACTIVE(pass), .O_ENGINE_CONNECT(eng), .O_EXITING(exg),
    .O_MASTER_SWITCH_SELECT(mq), .O_DETECT_START(det),
    .O_TIMEOUT_EVENT(tev));
  task chk(input string nm, input [3:0] e, input [3:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task hw(input e, input t, input r);
    @(posedge clk) wr <= 1'b1;
    {men, tx, rx} <= {e, t, r};
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  task wait_exit(input lvl);
    n = 0;
    while (exg !== lvl && n < 500) begin
      @(posedge clk) #1;
      n++;
    end
    if (exg !== lvl) begin
      err_total++;
      results;
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset", 4'h1, {stx, srx, pass, eng});
    for (i = 0; i < 4; i++) begin
      m.req(i[1:0]);
      #1;
      chk("sel", {2'b10, i[1:0]}, {pass, eng, stx, srx});
      hw(1'b0, 1'b0, 1'b0);
      chk("host_exit", 4'hC, {eng, det, stx, srx});
    end
    $display("test select done");
    m.req(2'b11);
    hw(1'b1, 1'b0, 1'b1);
    chk("override", 4'h5, {pass, stx, srx});
    hw(1'b0, 1'b0, 1'b0);
    m.own(4'h4);
    #1;
    chk("own_sw", 4'h4, {pass, stx, srx});
    chk("msel", 4'h4, mq);
    hw(1'b1, 1'b1, 1'b0);
    chk("own_close", 4'h2, {stx, srx});
    hw(1'b0, 1'b0, 1'b0);
    $display("test host done");
    @(posedge clk) tmo <= 1'b1;
    m.req(2'b10);
    m.burst(6);
    wait_exit(1'b1);
    chk("idle", 4'h1, n >= IDLE && n <= IDLE + 3);
    chk("m_hold", 4'h1, mpass);
    repeat (3) @(posedge clk) rxp <= ~rxp;
    wait_exit(1'b0);
    chk("exit_len", 4'h1, n + 3 == EXIT);
    chk("tmo_end", 4'h7, {eng, det, tev});
    chk("m_exit", 4'h0, mpass);
    $display("test timeout done");
    @(posedge clk) {tmo, auto} <= 2'b01;
    m.req(2'b01);
    #1;
    chk("auto_tx", 4'h2, {stx, srx});
    for (i = 0; i < 2; i++) begin
      @(posedge clk) rxp <= ~rxp;
      @(posedge clk) #1;
      chk("auto_rx", 4'h1, {stx, srx});
      repeat (blank) @(posedge clk) #1;
      chk("blank", 4'h1, {stx, srx});
      @(posedge clk) #1;
      chk("auto_back", 4'h2, {stx, srx});
      @(posedge clk) blank <= 16'h0002;
    end
    hw(1'b0, 1'b0, 1'b0);
    $display("test auto done");
    m.req(2'b11);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("rst_mid", 4'h1, {stx, srx, pass, eng});
    $display("test reset done");
    results;
  end
endmodule
bind lupc_ctrl lupc_chk u_chk (.I_CLK_SYS, .I_RST, .I_MODE_REQ_DONE,
  .I_HOST_WR, .I_HOST_MODE_EN, .I_HOST_TX_SW, .I_HOST_RX_SW, .I_TMO_EN,
  .I_AUTO_DIR_EN, .I_UART_RX_PIN, .O_SW_TX, .O_SW_RX, .O_PASS_ACTIVE,
  .O_ENGINE_CONNECT, .O_EXITING, .O_DETECT_START, .O_TIMEOUT_EVENT,
  .I_SLAVE_SWITCH_SELECT);
